// ===== logic/lfsp_map.vh
// Constants of the lock, fuse and self-programming control block.
// Assumes a single core clock domain; included by bare name.
`ifndef LFSP_MAP_VH
`define LFSP_MAP_VH

// Control field bit positions (bits 4 down to 0)
`define LFSP_BIT_STORE 0
`define LFSP_BIT_ERASE 1
`define LFSP_BIT_WRITE 2
`define LFSP_BIT_READ 3
`define LFSP_BIT_CLEAR 4
`define LFSP_CTL_W 5

// Accepted control patterns
`define LFSP_PAT_CLEAR 5'h11
`define LFSP_PAT_READ 5'h09
`define LFSP_PAT_WRITE 5'h05
`define LFSP_PAT_ERASE 5'h03
`define LFSP_PAT_STORE 5'h01
`define LFSP_PAT_NONE 5'h00

// Arming windows in core clock cycles
`define LFSP_STORE_WIN 3'h4
`define LFSP_LOAD_WIN 3'h3
`define LFSP_CNT_ZERO 3'h0
`define LFSP_CNT_ONE 3'h1

// Reset values of the nonvolatile bytes
`define LFSP_LOCK_DEF 8'hff
`define LFSP_EXT_DEF 8'hff
`define LFSP_HIGH_DEF 8'hdf
`define LFSP_LOW_DEF 8'h62
`define LFSP_ALL_ONES 8'hff
`define LFSP_READ_PAD 3'h0

// Lock bit positions
`define LFSP_LOCK_LOW 0
`define LFSP_LOCK_HIGH 1

// High fuse bit positions
`define LFSP_HI_EXT_RESET 7
`define LFSP_HI_DEBUG 6
`define LFSP_HI_SERIAL 5
`define LFSP_HI_WATCHDOG 4
`define LFSP_HI_PRESERVE 3

// Extended fuse bit position
`define LFSP_EXT_SELF_PROG 0

// Pointer values selecting a byte on a redirected load
`define LFSP_Z_FUSE_LOW 16'h0000
`define LFSP_Z_LOCK 16'h0001
`define LFSP_Z_FUSE_EXT 16'h0002
`define LFSP_Z_FUSE_HIGH 16'h0003

// Programmer fuse byte select codes
`define LFSP_SEL_LOW 2'h0
`define LFSP_SEL_HIGH 2'h1
`define LFSP_SEL_EXT 2'h2

`endif

// ===== logic/lfsp_sync.v
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to sys_clk.
module lfsp_sync (
   // Clock and reset
   input wire sys_clk,
   input wire rst_b,
   // Raw and filtered level
   input wire d,
   output reg q
);

reg stage1;
reg stage2;
reg stage3;

// Shift chain; output follows only when stages two and three agree
always @(posedge sys_clk or negedge rst_b) begin
   if (!rst_b) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      q <= 1'b0;
   end else begin
      stage1 <= d;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
         q <= stage3;
      end
   end
end

endmodule // lfsp_sync

// ===== logic/lfsp_ctrl.v
// Lock bit, fuse byte and self-programming store control.
// Assumes core strobes and programmer commands are on sys_clk;
// programming mode pins are asynchronous and are synchronised here.
//
// Notes on behaviour
// - Store-enable arms the store instruction for four following cycles.
// - Store-enable alone: store writes R1:R0 into buffer word at pointer.
// - Buffer fill ignores pointer bit zero; it addresses words.
// - Store-enable clears on store completion or after four idle cycles.
// - Store-enable stays set during page erase or write until done.
// - Only patterns 10001, 01001, 00101, 00011, 00001 act; others ignored.
// - Two lock bits, 0 programmed; only chip erase returns them to 1.
// - Programmed debug fuse lets debug link read memory despite locks.
// - Both lock bits 1: no memory protection.
// - Mode 2: refuse memory programming and fuse changes; debug off.
// - Mode 3: also refuse memory verify; debug link off.
// - Three fuse bytes low, high, extended; programmed reads as 0.
// - Extended bit 0 enables self-programming; defaults 1, rest read 1.
// - Serial-programming fuse defaults programmed; serial mode cannot alter.
// - Preserve fuse programmed keeps data memory through chip erase.
// - Low fuse defaults: divide-by-8 on, clock out off, 10, 0010.
// - Chip erase leaves all fuse bits unchanged.
// - Lower lock bit programmed: refuse any fuse change.
// - Fuses latch on programming entry; new values act after exit.
// - Preserve fuse acts as soon as programmed.
// - All fuses latch at power-up in normal operation.
// - Erase with store-enable: store within four cycles erases the page.
// - Read with store-enable: load within three cycles returns fuse/lock.
// - Clear-buffer write discards temporary buffer contents.
`include "lfsp_map.vh"

module lfsp_ctrl #(
   parameter PAGE_WORD_BITS = 5
) (
   // Clock and reset
   input wire sys_clk,
   input wire rst_b,
   // Core control register port
   input wire ctrl_wr,
   input wire [7:0] ctrl_wdata,
   output wire [7:0] ctrl_rdata,
   // Core instruction strobes and operands
   input wire store_instr,
   input wire load_instr,
   input wire [15:0] z_ptr,
   input wire [15:0] r1r0,
   // Page buffer and flash array side
   output reg buf_wr,
   output reg buf_clear,
   output reg [14:0] buf_word_addr,
   output reg [15:0] buf_wdata,
   output reg page_erase_start,
   output reg page_write_start,
   output reg [15-PAGE_WORD_BITS-1:0] page_addr,
   input wire page_op_done,
   output wire cpu_halt,
   // Redirected load answer
   output wire load_redirect,
   output reg load_valid,
   output reg [7:0] load_data,
   // Programmer pins and commands
   input wire prog_mode_pin,
   input wire prog_serial_pin,
   input wire prog_chip_erase,
   input wire prog_fuse_wr,
   input wire [1:0] prog_fuse_sel,
   input wire [7:0] prog_fuse_data,
   input wire prog_lock_wr,
   input wire [7:0] prog_lock_data,
   output reg prog_refused,
   output reg flash_erase,
   output reg data_mem_erase,
   output wire mem_prog_allow,
   output wire mem_verify_allow,
   output wire fuse_change_allow,
   // Debug link gating
   output wire debug_link_on,
   output wire debug_mem_read,
   // Active fuse values
   output reg [7:0] fuse_low_q,
   output reg [7:0] fuse_high_q,
   output reg [7:0] fuse_ext_q,
   output wire self_prog_ok
);

// Control states, one-hot
localparam ST_IDLE = 3'b001;
localparam ST_ARMED = 3'b010;
localparam ST_BUSY = 3'b100;
localparam PAGE_W = 15 - PAGE_WORD_BITS;

reg [2:0] state;
reg [2:0] next_state;
reg [`LFSP_CTL_W-1:0] ctl;
reg [`LFSP_CTL_W-1:0] next_ctl;
reg [2:0] win_cnt;
reg [2:0] next_win_cnt;

// Nonvolatile cells and latching state
reg [7:0] lock_bit_byte;
reg [7:0] fuse_low_byte;
reg [7:0] fuse_high_byte;
reg [7:0] fuse_extended_byte;
reg pwr_latched;
reg mode_prev;
wire prog_mode_q;
wire prog_serial_q;

// Accept only the five legal control patterns
function pattern_ok;
   input [`LFSP_CTL_W-1:0] pat;
   begin
      case (pat)
         `LFSP_PAT_CLEAR: pattern_ok = 1'b1;
         `LFSP_PAT_READ: pattern_ok = 1'b1;
         `LFSP_PAT_WRITE: pattern_ok = 1'b1;
         `LFSP_PAT_ERASE: pattern_ok = 1'b1;
         `LFSP_PAT_STORE: pattern_ok = 1'b1;
         default: pattern_ok = 1'b0;
      endcase
   end
endfunction

// Programmer mode pins cross into the core clock
lfsp_sync u_mode_sync (
   .sys_clk(sys_clk),
   .rst_b(rst_b),
   .d(prog_mode_pin),
   .q(prog_mode_q)
);

lfsp_sync u_serial_sync (
   .sys_clk(sys_clk),
   .rst_b(rst_b),
   .d(prog_serial_pin),
   .q(prog_serial_q)
);

// Protection decode from the live lock cells
wire lock_low_set = ~lock_bit_byte[`LFSP_LOCK_LOW];
wire lock_high_set = ~lock_bit_byte[`LFSP_LOCK_HIGH];
assign mem_prog_allow = ~lock_low_set;
assign mem_verify_allow = ~(lock_low_set & lock_high_set);
assign fuse_change_allow = prog_mode_q & ~lock_low_set;

// Debug link: locks switch it off, but memory read follows the fuse
wire debug_fuse_set = ~fuse_high_q[`LFSP_HI_DEBUG];
assign debug_link_on = debug_fuse_set & ~lock_low_set;
assign debug_mem_read = debug_fuse_set;

// Self-programming gated by the latched extended fuse
assign self_prog_ok = ~fuse_ext_q[`LFSP_EXT_SELF_PROG];

// Core halts while a page operation runs
assign cpu_halt = state[2];

// Register read shows the live control bits, reserved bits zero
assign ctrl_rdata = {`LFSP_READ_PAD, ctl};

// Window qualifiers
wire store_win = (win_cnt != `LFSP_CNT_ZERO);
wire load_win = (win_cnt > (`LFSP_STORE_WIN - `LFSP_LOAD_WIN));
wire is_read = (ctl == `LFSP_PAT_READ);
wire store_hit = state[1] & store_instr & store_win;
assign load_redirect = state[1] & is_read & load_instr & load_win;

// Next control state and window count
always @* begin
   next_state = state;
   next_ctl = ctl;
   next_win_cnt = win_cnt;
   case (state)
      ST_IDLE: begin
         if (ctrl_wr && pattern_ok(ctrl_wdata[`LFSP_CTL_W-1:0])) begin
            next_ctl = ctrl_wdata[`LFSP_CTL_W-1:0];
            next_win_cnt = `LFSP_STORE_WIN;
            next_state = ST_ARMED;
         end
      end
      ST_ARMED: begin
         next_win_cnt = win_cnt - `LFSP_CNT_ONE;
         if (load_redirect) begin
            next_ctl = `LFSP_PAT_NONE;
            next_win_cnt = `LFSP_CNT_ZERO;
            next_state = ST_IDLE;
         end else if (store_hit && (ctl == `LFSP_PAT_ERASE ||
                      ctl == `LFSP_PAT_WRITE) && self_prog_ok) begin
            next_win_cnt = `LFSP_CNT_ZERO;
            next_state = ST_BUSY;
         end else if (store_hit) begin
            next_ctl = `LFSP_PAT_NONE;
            next_win_cnt = `LFSP_CNT_ZERO;
            next_state = ST_IDLE;
         end else if (is_read && !load_win) begin
            next_ctl = `LFSP_PAT_NONE;
            next_win_cnt = `LFSP_CNT_ZERO;
            next_state = ST_IDLE;
         end else if (win_cnt == `LFSP_CNT_ONE) begin
            next_ctl = `LFSP_PAT_NONE;
            next_state = ST_IDLE;
         end
      end
      ST_BUSY: begin
         if (page_op_done) begin
            next_ctl = `LFSP_PAT_NONE;
            next_state = ST_IDLE;
         end
      end
      default: begin
         next_state = ST_IDLE;
         next_ctl = `LFSP_PAT_NONE;
         next_win_cnt = `LFSP_CNT_ZERO;
      end
   endcase
end

// Control state registers
always @(posedge sys_clk or negedge rst_b) begin
   if (!rst_b) begin
      state <= ST_IDLE;
      ctl <= `LFSP_PAT_NONE;
      win_cnt <= `LFSP_CNT_ZERO;
   end else begin
      state <= next_state;
      ctl <= next_ctl;
      win_cnt <= next_win_cnt;
   end
end

// Buffer fill, clear and page operation strobes
always @(posedge sys_clk or negedge rst_b) begin
   if (!rst_b) begin
      buf_wr <= 1'b0;
      buf_clear <= 1'b0;
      buf_word_addr <= 15'h0000;
      buf_wdata <= 16'h0000;
      page_erase_start <= 1'b0;
      page_write_start <= 1'b0;
      page_addr <= {PAGE_W{1'b0}};
   end else begin
      buf_wr <= 1'b0;
      buf_clear <= 1'b0;
      page_erase_start <= 1'b0;
      page_write_start <= 1'b0;
      if (state[0] && ctrl_wr &&
          ctrl_wdata[`LFSP_CTL_W-1:0] == `LFSP_PAT_CLEAR) begin
         buf_clear <= 1'b1;
      end
      if (store_hit && self_prog_ok) begin
         if (ctl == `LFSP_PAT_STORE) begin
            buf_wr <= 1'b1;
            buf_word_addr <= z_ptr[15:1];
            buf_wdata <= r1r0;
         end
         if (ctl == `LFSP_PAT_ERASE) begin
            page_erase_start <= 1'b1;
            page_addr <= z_ptr[15:PAGE_WORD_BITS+1];
         end
         if (ctl == `LFSP_PAT_WRITE) begin
            page_write_start <= 1'b1;
            page_addr <= z_ptr[15:PAGE_WORD_BITS+1];
         end
      end
   end
end

// Redirected load returns lock or fuse bytes, programmed as zero
always @(posedge sys_clk or negedge rst_b) begin
   if (!rst_b) begin
      load_valid <= 1'b0;
      load_data <= 8'h00;
   end else begin
      load_valid <= load_redirect;
      if (load_redirect) begin
         case (z_ptr)
            `LFSP_Z_FUSE_LOW: load_data <= fuse_low_byte;
            `LFSP_Z_LOCK: load_data <= lock_bit_byte;
            `LFSP_Z_FUSE_EXT: load_data <= fuse_extended_byte;
            `LFSP_Z_FUSE_HIGH: load_data <= fuse_high_byte;
            default: load_data <= `LFSP_ALL_ONES;
         endcase
      end
   end
end

// Fuse byte write data; serial mode keeps the serial-enable bit
reg [7:0] fuse_new;
always @* begin
   fuse_new = prog_fuse_data;
   if (prog_fuse_sel == `LFSP_SEL_HIGH && prog_serial_q) begin
      fuse_new[`LFSP_HI_SERIAL] = fuse_high_byte[`LFSP_HI_SERIAL];
   end
end

wire fuse_try = prog_mode_q & prog_fuse_wr;
wire fuse_take = fuse_try & fuse_change_allow;

// Nonvolatile cells: defaults at power-up, programmer writes
always @(posedge sys_clk or negedge rst_b) begin
   if (!rst_b) begin
      lock_bit_byte <= `LFSP_LOCK_DEF;
      fuse_low_byte <= `LFSP_LOW_DEF;
      fuse_high_byte <= `LFSP_HIGH_DEF;
      fuse_extended_byte <= `LFSP_EXT_DEF;
   end else if (prog_mode_q) begin
      if (prog_chip_erase) begin
         lock_bit_byte <= `LFSP_LOCK_DEF;
      end else if (prog_lock_wr) begin
         lock_bit_byte <= lock_bit_byte & prog_lock_data;
      end
      if (fuse_take && !prog_chip_erase) begin
         case (prog_fuse_sel)
            `LFSP_SEL_LOW: fuse_low_byte <= fuse_new;
            `LFSP_SEL_HIGH: fuse_high_byte <= fuse_new;
            `LFSP_SEL_EXT: fuse_extended_byte <= fuse_new;
            default: fuse_low_byte <= fuse_low_byte;
         endcase
      end
   end
end

// Chip erase strobes; preserve fuse read live from its cell
always @(posedge sys_clk or negedge rst_b) begin
   if (!rst_b) begin
      flash_erase <= 1'b0;
      data_mem_erase <= 1'b0;
      prog_refused <= 1'b0;
   end else begin
      flash_erase <= prog_mode_q & prog_chip_erase;
      data_mem_erase <= prog_mode_q & prog_chip_erase &
                        fuse_high_byte[`LFSP_HI_PRESERVE];
      prog_refused <= fuse_try & ~fuse_change_allow;
   end
end

// Active fuse copies: latched at power-up and on mode entry and exit
always @(posedge sys_clk or negedge rst_b) begin
   if (!rst_b) begin
      pwr_latched <= 1'b0;
      mode_prev <= 1'b0;
      fuse_low_q <= `LFSP_LOW_DEF;
      fuse_high_q <= `LFSP_HIGH_DEF;
      fuse_ext_q <= `LFSP_EXT_DEF;
   end else begin
      pwr_latched <= 1'b1;
      mode_prev <= prog_mode_q;
      if (!pwr_latched || (prog_mode_q != mode_prev)) begin
         fuse_low_q <= fuse_low_byte;
         fuse_high_q <= fuse_high_byte;
         fuse_ext_q <= fuse_extended_byte;
      end
   end
end

endmodule // lfsp_ctrl

// ===== test/lfsp_ctrl_chk.sv
// Checker for the lock, fuse and store control block.
// Assumes it sees only the top module ports; bound after the module.
module lfsp_ctrl_chk (
   // Clock and reset
   input wire sys_clk,
   input wire rst_b,
   // Core side
   input wire ctrl_wr,
   input wire [7:0] ctrl_wdata,
   input wire [7:0] ctrl_rdata,
   input wire store_instr,
   input wire load_instr,
   input wire [15:0] z_ptr,
   input wire buf_wr,
   input wire buf_clear,
   input wire [14:0] buf_word_addr,
   input wire page_erase_start,
   input wire page_op_done,
   input wire cpu_halt,
   input wire load_redirect,
   input wire load_valid,
   // Programmer and gating
   input wire prog_fuse_wr,
   input wire prog_refused,
   input wire mem_prog_allow,
   input wire mem_verify_allow,
   input wire fuse_change_allow,
   input wire debug_link_on,
   input wire self_prog_ok
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // Control register free to take a write
   wire idle = ctrl_rdata[4:0] == 5'h00 && !cpu_halt;

   property p_store; ctrl_rdata[4:0] == 5'h01 && store_instr && self_prog_ok
      |=> buf_wr && buf_word_addr == $past(z_ptr[15:1]); endproperty
   a_store: assert property (p_store) else $error("store word missed");
   property p_win; $rose(ctrl_rdata[0]) ##0 (!store_instr && !load_instr) [*4]
      |=> ctrl_rdata[4:0] == 5'h00; endproperty
   a_win: assert property (p_win) else $error("arming outlived window");
   property p_hold; cpu_halt && !page_op_done |=> cpu_halt && ctrl_rdata[0];
   endproperty
   a_hold: assert property (p_hold) else $error("enable dropped in op");
   property p_erase; ctrl_rdata[4:0] == 5'h03 && store_instr && self_prog_ok
      |=> page_erase_start && cpu_halt; endproperty
   a_erase: assert property (p_erase) else $error("page erase missed");
   property p_ill; ctrl_wr && idle && !(ctrl_wdata[4:0] inside
      {5'h11, 5'h09, 5'h05, 5'h03, 5'h01}) |=> ctrl_rdata[4:0] == 5'h00;
   endproperty
   a_ill: assert property (p_ill) else $error("bad pattern acted");
   property p_clear; ctrl_wr && idle && ctrl_wdata[4:0] == 5'h11
      |-> ##[1:2] buf_clear; endproperty
   a_clear: assert property (p_clear) else $error("buffer not cleared");
   // A load after three armed cycles is outside the window
   property p_read; ctrl_rdata[4:0] == 5'h09 && load_instr &&
      !($past(ctrl_rdata[3]) && $past(ctrl_rdata[3], 2) &&
      $past(ctrl_rdata[3], 3))
      |-> load_redirect ##1 load_valid; endproperty
   a_read: assert property (p_read) else $error("load not redirected");
   property p_ref; prog_refused
      |-> $past(prog_fuse_wr) && !$past(fuse_change_allow); endproperty
   a_ref: assert property (p_ref) else $error("refusal without cause");
   property p_lock; !mem_verify_allow
      |-> !mem_prog_allow && !fuse_change_allow && !debug_link_on; endproperty
   a_lock: assert property (p_lock) else $error("full lock leaks");
   property p_dbg; !mem_prog_allow |-> !debug_link_on; endproperty
   a_dbg: assert property (p_dbg) else $error("debug on while locked");
endmodule // lfsp_ctrl_chk

bind lfsp_ctrl lfsp_ctrl_chk lfsp_ctrl_chk_i (.sys_clk(sys_clk),
   .rst_b(rst_b), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
   .ctrl_rdata(ctrl_rdata), .store_instr(store_instr),
   .load_instr(load_instr), .z_ptr(z_ptr), .buf_wr(buf_wr),
   .buf_clear(buf_clear), .buf_word_addr(buf_word_addr),
   .page_erase_start(page_erase_start), .page_op_done(page_op_done),
   .cpu_halt(cpu_halt), .load_redirect(load_redirect),
   .load_valid(load_valid), .prog_fuse_wr(prog_fuse_wr),
   .prog_refused(prog_refused), .mem_prog_allow(mem_prog_allow),
   .mem_verify_allow(mem_verify_allow),
   .fuse_change_allow(fuse_change_allow),
   .debug_link_on(debug_link_on), .self_prog_ok(self_prog_ok));

// ===== test/lfsp_flash_model.sv
// Flash array stand-in answering page erase and page write starts.
// Assumes one start pulse at a time, on sys_clk.
module lfsp_flash_model (
   // Clock and reset
   input wire sys_clk,
   input wire rst_b,
   // Array side
   input wire start,
   input wire slow,
   output logic done
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   // Busy for a short or long time, then one done pulse
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 0;
         done <= 1'b0;
      end else begin
         done <= cnt == 1;
         if (start) cnt <= slow ? 40 : 3;
         else if (cnt != 0) cnt <= cnt - 1;
      end
   end
endmodule // lfsp_flash_model

// ===== test/tb_lfsp_ctrl.sv
// Self-checking bench for the lock, fuse and store control block.
// Assumes a 25 MHz core clock and the flash model as far side.
`include "lfsp_map.vh"
module tb_lfsp_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   // Inputs, all given values at time zero
   logic sys_clk = 1'b0, rst_b = 1'b0, ctrl_wr = 1'b0, slow = 1'b0;
   logic store_instr = 1'b0, load_instr = 1'b0, prog_mode_pin = 1'b0;
   logic prog_serial_pin = 1'b0, prog_chip_erase = 1'b0;
   logic prog_fuse_wr = 1'b0, prog_lock_wr = 1'b0;
   logic [1:0] prog_fuse_sel = 2'h0;
   logic [7:0] ctrl_wdata = 8'h00, prog_fuse_data = 8'h00;
   logic [7:0] prog_lock_data = 8'hff;
   logic [15:0] z_ptr = 16'h0000, r1r0 = 16'h0000, z, d;
   // Outputs
   wire buf_wr, buf_clear, page_erase_start, page_write_start, cpu_halt;
   wire load_redirect, load_valid, prog_refused, flash_erase;
   wire data_mem_erase, mem_prog_allow, mem_verify_allow, page_op_done;
   wire fuse_change_allow, debug_link_on, debug_mem_read, self_prog_ok;
   wire [14:0] buf_word_addr;
   wire [15:0] buf_wdata;
   wire [9:0] page_addr;
   wire [7:0] ctrl_rdata, load_data, fuse_low_q, fuse_high_q, fuse_ext_q;
   wire op_start = page_erase_start | page_write_start;
   int n_fail = 0, n_checks = 0;
   logic [30:0] exp_buf [$];
   logic [7:0] exp_load [$];
   logic [11:0] exp_page [$];
   logic [7:0] rd_exp [4] = '{8'h62, 8'hff, 8'hff, 8'hdf};
   logic [4:0] p;

   lfsp_ctrl lfsp_ctrl_i (.sys_clk, .rst_b, .ctrl_wr, .ctrl_wdata,
      .ctrl_rdata, .store_instr, .load_instr, .z_ptr, .r1r0, .buf_wr,
      .buf_clear, .buf_word_addr, .buf_wdata, .page_erase_start,
      .page_write_start, .page_addr, .page_op_done, .cpu_halt,
      .load_redirect, .load_valid, .load_data, .prog_mode_pin,
      .prog_serial_pin, .prog_chip_erase, .prog_fuse_wr, .prog_fuse_sel,
      .prog_fuse_data, .prog_lock_wr, .prog_lock_data, .prog_refused,
      .flash_erase, .data_mem_erase, .mem_prog_allow, .mem_verify_allow,
      .fuse_change_allow, .debug_link_on, .debug_mem_read, .fuse_low_q,
      .fuse_high_q, .fuse_ext_q, .self_prog_ok);
   lfsp_flash_model lfsp_flash_model_i (.sys_clk(sys_clk), .rst_b(rst_b),
      .start(op_start), .slow(slow), .done(page_op_done));

   always #20 sys_clk = ~sys_clk;

   task automatic chk(input string what, input logic [31:0] e, g);
      n_checks++;
      if (e !== g) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic final_report;
      int left;
      // Every noted result must have appeared
      left = exp_buf.size() + exp_load.size() + exp_page.size();
      chk("pending", 0, left);
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Control write, then one strobe gap cycles later
   task automatic arm(input [4:0] pt, input [15:0] za, da, input st, ld,
                      input int gap);
      logic [4:0] ec;
      ec = (pt inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01}) ? pt : 5'h00;
      @(negedge sys_clk);
      ctrl_wr = 1'b1;
      ctrl_wdata = {3'h0, pt};
      @(negedge sys_clk);
      ctrl_wr = 1'b0;
      chk("ctl", ec, ctrl_rdata);
      repeat (gap - 1) @(negedge sys_clk);
      z_ptr = za;
      r1r0 = da;
      store_instr = st;
      load_instr = ld;
      @(negedge sys_clk);
      store_instr = 1'b0;
      load_instr = 1'b0;
      repeat (3) @(negedge sys_clk);
      for (int i = 0; i < 200 && cpu_halt !== 1'b0; i++) @(negedge sys_clk);
   endtask

   // Programmer strobe: k is {chip erase, lock write, fuse write}
   task automatic prog(input logic [2:0] k, input [1:0] sel,
                       input [7:0] v);
      @(negedge sys_clk);
      prog_fuse_sel = sel;
      prog_fuse_data = v;
      prog_lock_data = v;
      {prog_chip_erase, prog_lock_wr, prog_fuse_wr} = k;
      @(negedge sys_clk);
      {prog_chip_erase, prog_lock_wr, prog_fuse_wr} = 3'h0;
   endtask

   task automatic mode(input logic m);
      @(negedge sys_clk);
      prog_mode_pin = m;
      repeat (8) @(negedge sys_clk);
   endtask

   // Take the oldest note whenever a result appears
   always @(negedge sys_clk) begin
      if (buf_wr === 1'b1 && exp_buf.size() == 0) chk("buf_wr", 0, 1);
      else if (buf_wr === 1'b1)
         chk("buf", exp_buf.pop_front(), {buf_word_addr, buf_wdata});
      if (load_valid === 1'b1 && exp_load.size() == 0) chk("load", 0, 1);
      else if (load_valid === 1'b1)
         chk("load_data", exp_load.pop_front(), load_data);
      if (op_start === 1'b1 && exp_page.size() == 0) chk("op", 0, 1);
      else if (op_start === 1'b1)
         chk("page", exp_page.pop_front(),
             {page_write_start, page_erase_start, page_addr});
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      final_report;
   end

   initial begin
      void'($urandom(32'hc6bee0f4));
      repeat (10) @(negedge sys_clk);
      rst_b = 1'b1;
      @(negedge sys_clk);
      chk("low", 8'h62, fuse_low_q);
      chk("high", 8'hdf, fuse_high_q);
      chk("ext", 8'hff, fuse_ext_q);
      chk("open", 3'h6, {mem_prog_allow, mem_verify_allow, fuse_change_allow});
      for (int i = 0; i < 4; i++) begin
         exp_load.push_back(rd_exp[i]);
         arm(5'h09, i, 0, 0, 1, 1 + i % 3);
      end
      arm(5'h01, $urandom, $urandom, 1, 0, 2);
      $display("test defaults done");
      prog_serial_pin = 1'b1;
      mode(1);
      prog(3'h1, `LFSP_SEL_EXT, 8'hfe);
      prog(3'h1, `LFSP_SEL_HIGH, 8'hb7);
      chk("held ext", 8'hff, fuse_ext_q);
      mode(0);
      chk("ext", 8'hfe, fuse_ext_q);
      chk("high", 8'h97, fuse_high_q);
      chk("debug", 2'h3, {debug_link_on, debug_mem_read});
      $display("test fuse latch done");
      for (int g = 1; g <= 5; g++) begin
         z = $urandom;
         d = $urandom;
         if (g < 5) exp_buf.push_back({z[15:1], d});
         arm(5'h01, z, d, 1, 0, g);
      end
      for (int i = 0; i < 6; i++) begin
         p = (i == 0) ? 5'h11 : (i == 1) ? 5'h05 : (i == 2) ? 5'h03 :
             5'($urandom) | 5'h06;
         slow = i[0];
         z = $urandom;
         // Pattern bits 2 and 1 pick page write or page erase
         if (i == 1 || i == 2) exp_page.push_back({p[2:1], z[15:6]});
         arm(p, z, $urandom, 1, 0, 1);
      end
      $display("test store done");
      mode(1);
      prog(3'h2, 2'h0, 8'hfe);
      chk("mode2", 4'h8, {mem_verify_allow, mem_prog_allow,
          fuse_change_allow, debug_link_on});
      prog(3'h1, `LFSP_SEL_LOW, 8'h00);
      chk("refused", 1'b1, prog_refused);
      prog(3'h2, 2'h0, 8'hfd);
      chk("mode3", 5'h01, {mem_verify_allow, mem_prog_allow,
          fuse_change_allow, debug_link_on, debug_mem_read});
      prog(3'h4, 2'h0, 8'h00);
      chk("erase", 2'h2, {flash_erase, data_mem_erase});
      mode(0);
      chk("fuses", 24'h6297fe, {fuse_low_q, fuse_high_q, fuse_ext_q});
      exp_load.push_back(8'hff);
      arm(5'h09, 1, 0, 0, 1, 3);
      $display("test locks done");
      final_report;
   end
endmodule // tb_lfsp_ctrl
